// ==== common/shwc_pkg.sv ====
// constants, types and register map of the standby, halt and wake control block
package shwc_pkg;

    // register byte offsets on the Avalon-MM slave
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] WARM_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] HOLD_OFS = 4'hc;

    // control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_DRIVE_BIT = 2;
    localparam int unsigned CTRL_SYSTEM_CLOCK_SELECT_BIT = 3;
    localparam int unsigned CTRL_I0P_LSB = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;

    // warm-up register: number of states counted on stop release
    localparam logic [15:0] WARM_RESET = 16'h0100;

    // status register fields
    localparam int unsigned STAT_HALT_BIT = 0;
    localparam int unsigned STAT_ENTER_BIT = 1;
    localparam int unsigned STAT_WARM_BIT = 2;
    localparam int unsigned STAT_HELD_BIT = 3;
    localparam int unsigned STAT_QCNT_LSB = 4;
    localparam int unsigned STAT_WPRE_BIT = 8;
    localparam int unsigned STAT_WADC_BIT = 9;

    // hold register fields
    localparam int unsigned HOLD_SRC_LSB = 0;
    localparam int unsigned HOLD_PRIO_LSB = 4;
    localparam int unsigned HOLD_VALID_BIT = 8;

    // halt modes selected in the control register
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_PERIPHERAL_RUNNING_IDLE_MODE = 2'h1;
    localparam logic [1:0] MODE_OSCILLATOR_ONLY_IDLE_MODE = 2'h2;
    localparam logic [1:0] MODE_STOP = 2'h3;

    // timing counts in selected peripheral clock cycles
    localparam logic [1:0] HALT_ENTRY_CYCLES = 2'h3;
    localparam logic [0:0] STATE_DIV_LAST = 1'h1;

    // fixed priority of the non-maskable request
    localparam logic [2:0] NMI_PRIO = 3'h7;

    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_NMI,
        SRC_EXTERNAL_INTERRUPT_ZERO,
        SRC_OTHER
    } shwc_src_e;

    // one wake request: source and its priority
    typedef struct packed {
        logic valid;
        shwc_src_e src;
        logic [2:0] prio;
    } shwc_req_s;

endpackage

// ==== verilog/shwc_warmup.sv ====
// warm-up counter run on every stop release, counted in states
`timescale 1ns/1ps
`default_nettype none
module shwc_warmup (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic i_tick,
    input wire logic [15:0] i_count,
    output logic o_busy
);
    logic [15:0] cnt_q;

    // a zero count still runs one state, so the delay is never skipped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 16'h0000;
        end else if (i_ce) begin
            if (i_start) begin
                cnt_q <= (i_count == 16'h0000) ? 16'h0001 : i_count;
            end else if (i_tick && cnt_q != 16'h0000) begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    assign o_busy = (cnt_q != 16'h0000);
endmodule
`default_nettype wire

// ==== verilog/shwc_top.sv ====
// standby, halt and wake control with its Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - state clock is selected clock halved
// - stop release always runs warm-up first
// - nmi/external_interrupt_zero during oscillator_only_idle_mode/stop entry held
// - peripheral_running_idle_mode and run halts always wake
// - wake services higher of new and held first, then the other
// - stop with drive bit clear: outputs open-drain, inputs stay live
// - stop signal high through stop entry and halt unless drive bit set
module shwc_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_halt_exec,
    input wire logic i_nmi,
    input wire logic i_external_interrupt_zero,
    input wire logic i_irq_other,
    input wire logic [2:0] i_irq_other_prio,
    input wire logic i_prescaler_run,
    input wire logic i_ladder_on,
    input wire logic [1:0] i_conv_speed,
    input wire logic i_svc_ack,
    output logic o_svc_valid,
    output shwc_pkg::shwc_req_s o_svc,
    output logic o_halted,
    output logic o_sysclk_run,
    output logic o_sysclk_sel,
    output logic o_state_tick,
    output logic o_stop,
    output logic o_pins_open_drain,
    output logic o_input_gate_en
);
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_HALT,
        ST_WARM
    } shwc_state_e;

    shwc_state_e st_q;
    logic [31:0] ctrl_q;
    logic [15:0] warm_q;
    logic [1:0] mode_q;
    logic [1:0] enter_cnt_q;
    logic state_div_q;
    logic stop_q;
    logic warn_pre_q;
    logic warn_adc_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic warm_busy;
    logic wake_go;
    logic halt_go;
    logic held_first;
    logic bus_req;
    logic bus_wr;
    logic [1:0] qcnt;
    logic [1:0] ctrl_mode;
    logic [2:0] external_interrupt_zero_prio;
    logic [31:0] rdata_d;
    shwc_pkg::shwc_req_s held_q;
    shwc_pkg::shwc_req_s q0_q;
    shwc_pkg::shwc_req_s q1_q;
    shwc_pkg::shwc_req_s req_ext;
    shwc_pkg::shwc_req_s req_now;

    function automatic shwc_pkg::shwc_req_s mk_req(input logic v, input shwc_pkg::shwc_src_e s,
                                                   input logic [2:0] p);
        shwc_pkg::shwc_req_s r;
        r.valid = v;
        r.src = v ? s : shwc_pkg::SRC_NONE;
        r.prio = v ? p : 3'h0;
        return r;
    endfunction

    // first argument wins a tie, so an older request keeps its place
    function automatic shwc_pkg::shwc_req_s higher(input shwc_pkg::shwc_req_s a, input shwc_pkg::shwc_req_s b);
        return (a.valid && (!b.valid || a.prio >= b.prio)) ? a : b;
    endfunction

    assign ctrl_mode = ctrl_q[shwc_pkg::CTRL_MODE_LSB +: 2];
    assign external_interrupt_zero_prio = ctrl_q[shwc_pkg::CTRL_I0P_LSB +: 3];

    // request sources: only nmi and external_interrupt_zero can be caught in the entry window
    assign req_ext = higher(mk_req(i_nmi, shwc_pkg::SRC_NMI, shwc_pkg::NMI_PRIO),
                            mk_req(i_external_interrupt_zero, shwc_pkg::SRC_EXTERNAL_INTERRUPT_ZERO, external_interrupt_zero_prio));
    assign req_now = higher(req_ext, mk_req(i_irq_other, shwc_pkg::SRC_OTHER, i_irq_other_prio));

    assign halt_go = (st_q == ST_RUN) && i_halt_exec;
    assign wake_go = (st_q == ST_HALT) && req_now.valid;
    assign held_first = held_q.valid && (!req_now.valid || held_q.prio >= req_now.prio);

    // state clock: one state is two selected clock cycles
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_div_q <= 1'b0;
        end else if (i_ce) begin
            state_div_q <= (state_div_q == shwc_pkg::STATE_DIV_LAST) ? 1'b0 : 1'b1;
        end
    end

    // halt sequencer
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q <= ST_RUN;
            mode_q <= shwc_pkg::MODE_RUN;
            enter_cnt_q <= 2'h0;
        end else if (i_ce) begin
            case (st_q)
                ST_RUN: begin
                    if (i_halt_exec) begin
                        mode_q <= ctrl_mode;
                        enter_cnt_q <= 2'h0;
                        if (ctrl_mode == shwc_pkg::MODE_OSCILLATOR_ONLY_IDLE_MODE || ctrl_mode == shwc_pkg::MODE_STOP) begin
                            st_q <= ST_ENTER;
                        end else begin
                            st_q <= ST_HALT;
                        end
                    end
                end
                ST_ENTER: begin
                    enter_cnt_q <= enter_cnt_q + 2'h1;
                    if (enter_cnt_q == shwc_pkg::HALT_ENTRY_CYCLES - 2'h1) begin
                        st_q <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (req_now.valid) begin
                        st_q <= (mode_q == shwc_pkg::MODE_STOP) ? ST_WARM : ST_RUN;
                    end
                end
                ST_WARM: begin
                    if (!warm_busy) begin
                        st_q <= ST_RUN;
                    end
                end
                default: begin
                    st_q <= ST_RUN;
                end
            endcase
        end
    end

    // request held during the entry window; it alone cannot wake the core
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            held_q <= '0;
        end else if (i_ce) begin
            if (wake_go) begin
                held_q <= '0;
            end else if (st_q == ST_ENTER && req_ext.valid) begin
                held_q <= higher(held_q, req_ext);
            end
        end
    end

    // service queue: higher of new and held goes first, the other after
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q0_q <= '0;
            q1_q <= '0;
        end else if (i_ce) begin
            if (wake_go) begin
                q0_q <= held_first ? held_q : req_now;
                q1_q <= held_first ? req_now : held_q;
            end else if (o_svc_valid && i_svc_ack) begin
                q0_q <= q1_q;
                q1_q <= '0;
            end
        end
    end

    // internal stop signal, dropped once the wake is taken
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stop_q <= 1'b0;
        end else if (i_ce) begin
            if (halt_go) begin
                stop_q <= (ctrl_mode == shwc_pkg::MODE_STOP) && !ctrl_q[shwc_pkg::CTRL_DRIVE_BIT];
            end else if (wake_go) begin
                stop_q <= 1'b0;
            end
        end
    end

    // software misuse flags; a new hit wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            warn_pre_q <= 1'b0;
            warn_adc_q <= 1'b0;
        end else if (i_ce) begin
            if (halt_go && ctrl_mode == shwc_pkg::MODE_OSCILLATOR_ONLY_IDLE_MODE && i_prescaler_run) begin
                warn_pre_q <= 1'b1;
            end else if (bus_wr && i_avs_address == shwc_pkg::STAT_OFS && i_avs_byteenable[1] &&
                         i_avs_writedata[shwc_pkg::STAT_WPRE_BIT]) begin
                warn_pre_q <= 1'b0;
            end
            if (halt_go && ctrl_mode != shwc_pkg::MODE_RUN && (i_ladder_on || i_conv_speed != 2'h0)) begin
                warn_adc_q <= 1'b1;
            end else if (bus_wr && i_avs_address == shwc_pkg::STAT_OFS && i_avs_byteenable[1] &&
                         i_avs_writedata[shwc_pkg::STAT_WADC_BIT]) begin
                warn_adc_q <= 1'b0;
            end
        end
    end

    shwc_warmup u_warmup (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_start(wake_go && mode_q == shwc_pkg::MODE_STOP),
        .i_tick(state_div_q),
        .i_count(warm_q),
        .o_busy(warm_busy)
    );

    // bus slave: one wait state per access, writes land when waitrequest is low
    assign bus_req = i_avs_read || i_avs_write;
    assign bus_wr = i_avs_write && ack_q;
    assign o_avs_waitrequest = bus_req && !(ack_q && i_ce);
    assign o_avs_readdata = rdata_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            ack_q <= bus_req && !ack_q;
            if (i_avs_read && !ack_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // writable registers, byte lanes honoured
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= shwc_pkg::CTRL_RESET;
            warm_q <= shwc_pkg::WARM_RESET;
        end else if (i_ce && bus_wr) begin
            if (i_avs_address == shwc_pkg::CTRL_OFS && i_avs_byteenable[0]) begin
                ctrl_q[7:0] <= {1'b0, i_avs_writedata[6:0]};
            end
            if (i_avs_address == shwc_pkg::WARM_OFS) begin
                if (i_avs_byteenable[0]) begin
                    warm_q[7:0] <= i_avs_writedata[7:0];
                end
                if (i_avs_byteenable[1]) begin
                    warm_q[15:8] <= i_avs_writedata[15:8];
                end
            end
        end
    end

    assign qcnt = {1'b0, q0_q.valid} + {1'b0, q1_q.valid};

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (i_avs_address)
            shwc_pkg::CTRL_OFS: rdata_d = ctrl_q;
            shwc_pkg::WARM_OFS: rdata_d = {16'h0000, warm_q};
            shwc_pkg::STAT_OFS: begin
                rdata_d[shwc_pkg::STAT_HALT_BIT] = (st_q == ST_HALT);
                rdata_d[shwc_pkg::STAT_ENTER_BIT] = (st_q == ST_ENTER);
                rdata_d[shwc_pkg::STAT_WARM_BIT] = (st_q == ST_WARM);
                rdata_d[shwc_pkg::STAT_HELD_BIT] = held_q.valid;
                rdata_d[shwc_pkg::STAT_QCNT_LSB +: 2] = qcnt;
                rdata_d[shwc_pkg::STAT_WPRE_BIT] = warn_pre_q;
                rdata_d[shwc_pkg::STAT_WADC_BIT] = warn_adc_q;
            end
            shwc_pkg::HOLD_OFS: begin
                rdata_d[shwc_pkg::HOLD_SRC_LSB +: 2] = held_q.src;
                rdata_d[shwc_pkg::HOLD_PRIO_LSB +: 3] = held_q.prio;
                rdata_d[shwc_pkg::HOLD_VALID_BIT] = held_q.valid;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // outputs decoded from state flops; input gate enable tied high
    assign o_svc_valid = q0_q.valid && (st_q == ST_RUN);
    assign o_svc = q0_q;
    assign o_halted = (st_q != ST_RUN);
    assign o_sysclk_run = (st_q == ST_RUN);
    assign o_sysclk_sel = ctrl_q[shwc_pkg::CTRL_SYSTEM_CLOCK_SELECT_BIT];
    assign o_state_tick = state_div_q;
    assign o_stop = stop_q;
    assign o_pins_open_drain = stop_q;
    assign o_input_gate_en = 1'b1;

    // checks; a frozen clock enable aborts any attempt in flight
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || !i_ce);

    sequence s_stop_wake;
        (st_q == ST_HALT) && req_now.valid && (mode_q == shwc_pkg::MODE_STOP);
    endsequence

    sequence s_entry_start;
        halt_go && (ctrl_mode == shwc_pkg::MODE_OSCILLATOR_ONLY_IDLE_MODE || ctrl_mode == shwc_pkg::MODE_STOP);
    endsequence

    property p_state_clk;
        o_state_tick |=> !o_state_tick ##1 o_state_tick;
    endproperty
    a_state_clk: assert property (p_state_clk) else $error("state clock is not half rate");

    property p_warm_after_stop;
        s_stop_wake |=> (st_q == ST_WARM) && warm_busy && !o_sysclk_run;
    endproperty
    a_warm_after_stop: assert property (p_warm_after_stop) else $error("stop release skipped warm-up");

    property p_hold_in_entry;
        ((st_q == ST_ENTER) && (i_nmi || i_external_interrupt_zero)) |=> held_q.valid && (st_q != ST_RUN);
    endproperty
    a_hold_in_entry: assert property (p_hold_in_entry) else $error("entry request not held");

    property p_peripheral_running_idle_mode_wakes;
        (halt_go && (ctrl_mode == shwc_pkg::MODE_PERIPHERAL_RUNNING_IDLE_MODE || ctrl_mode == shwc_pkg::MODE_RUN))
            |=> (st_q == ST_HALT) && !held_q.valid;
    endproperty
    a_peripheral_running_idle_mode_wakes: assert property (p_peripheral_running_idle_mode_wakes) else $error("peripheral_running_idle_mode or run halt took entry window");

    property p_prio_order;
        wake_go && held_q.valid |=> q0_q.valid && q1_q.valid && (q0_q.prio >= q1_q.prio);
    endproperty
    a_prio_order: assert property (p_prio_order) else $error("wake service order wrong");

    // stop must only ever be seen from halt entry up to the wake edge
    property p_stop_pins;
        o_stop |-> o_pins_open_drain && o_input_gate_en && (st_q == ST_ENTER || st_q == ST_HALT);
    endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("stop pins not open-drain");

    property p_stop_drive;
        (halt_go && ctrl_mode == shwc_pkg::MODE_STOP) |=> (o_stop == !$past(ctrl_q[shwc_pkg::CTRL_DRIVE_BIT]));
    endproperty
    a_stop_drive: assert property (p_stop_drive) else $error("stop signal ignores drive bit");

    property p_entry_len;
        s_entry_start |=> (st_q == ST_ENTER)[*3] ##1 (st_q == ST_HALT);
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry window length wrong");
endmodule
`default_nettype wire

// ==== tb/shwc_core_model.sv ====
// core-side partner: parks timer and converter, executes halt, accepts services
`timescale 1ns/1ps
`default_nettype none
module shwc_core_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [1:0] i_mode,
    input wire logic i_ack_slow,
    input wire logic i_sysclk_run,
    input wire logic i_svc_valid,
    output logic o_halt_exec,
    output logic o_prescaler_run,
    output logic o_ladder_on,
    output logic [1:0] o_conv_speed,
    output logic o_svc_ack
);
    logic go_q;
    logic parked_q;
    logic run_q;
    // park one cycle ahead of the halt pulse; unpark only once clocks are delivered again
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            go_q <= 1'b0;
            o_halt_exec <= 1'b0;
            parked_q <= 1'b0;
            run_q <= 1'b1;
        end else begin
            go_q <= i_go;
            o_halt_exec <= go_q;
            run_q <= i_sysclk_run;
            if (i_go) begin
                parked_q <= 1'b1;
            end else if (i_sysclk_run && !run_q) begin
                parked_q <= 1'b0;
            end
        end
    end
    // prescaler stopped before an oscillator-only idle halt
    assign o_prescaler_run = !(parked_q && i_mode == shwc_pkg::MODE_OSCILLATOR_ONLY_IDLE_MODE);
    // ladder cut and slowest speed code while parked
    assign o_ladder_on = !parked_q;
    assign o_conv_speed = parked_q ? 2'h0 : 2'h3;
    // a slow core takes every other cycle, so the queue is seen draining under stall
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_svc_ack <= 1'b0;
        end else begin
            o_svc_ack <= i_svc_valid && !(i_ack_slow && o_svc_ack);
        end
    end
endmodule
`default_nettype wire

// ==== tb/standby_halt_wake_control_bench.sv ====
// self-checking bench for the standby, halt and wake control block
`timescale 1ns/1ps
`default_nettype none
module standby_halt_wake_control_bench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic halt_go = 1'b0;
    logic [1:0] halt_mode = 2'h0;
    logic ack_slow = 1'b0;
    logic nmi = 1'b0;
    logic external_interrupt_zero = 1'b0;
    logic other = 1'b0;
    logic [2:0] other_prio = 3'h0;
    logic halt_exec, prescaler_run, ladder_on, svc_ack, svc_valid, halted, sysclk_run;
    logic sysclk_sel, state_tick, stop, pins_od, gate_en;
    logic [1:0] conv_speed;
    shwc_pkg::shwc_req_s svc;
    shwc_pkg::shwc_req_s log_q[$];
    int n_fail = 0;
    int samples_checked = 0;

    always #2.5 i_clk = ~i_clk;

    shwc_top i_shwc_top (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .i_halt_exec(halt_exec), .i_nmi(nmi), .i_external_interrupt_zero(external_interrupt_zero), .i_irq_other(other),
        .i_irq_other_prio(other_prio), .i_prescaler_run(prescaler_run), .i_ladder_on(ladder_on),
        .i_conv_speed(conv_speed), .i_svc_ack(svc_ack), .o_svc_valid(svc_valid), .o_svc(svc),
        .o_halted(halted), .o_sysclk_run(sysclk_run), .o_sysclk_sel(sysclk_sel),
        .o_state_tick(state_tick), .o_stop(stop), .o_pins_open_drain(pins_od), .o_input_gate_en(gate_en));

    shwc_core_model i_shwc_core_model (.i_clk(i_clk), .i_rst(i_rst), .i_go(halt_go), .i_mode(halt_mode),
        .i_ack_slow(ack_slow), .i_sysclk_run(sysclk_run), .i_svc_valid(svc_valid), .o_halt_exec(halt_exec),
        .o_prescaler_run(prescaler_run), .o_ladder_on(ladder_on), .o_conv_speed(conv_speed),
        .o_svc_ack(svc_ack));

    // every accepted service, in the order the core took it
    always @(posedge i_clk) begin
        if (svc_valid === 1'b1 && svc_ack === 1'b1) begin
            log_q.push_back(svc);
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic give_up;
        n_fail++;
        report_and_stop();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one Avalon access: hold until waitrequest is sampled low, then release
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge i_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (avs_waitrequest !== 1'b0) give_up();
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge i_clk);
    endtask

    // halt, then poke 1 = external_interrupt_zero, 2 = nmi in the second cycle of entry
    task automatic halt_and_poke(input logic [1:0] m, input int poke, input logic e_stop);
        int n;
        n = 0;
        halt_mode <= m;
        halt_go <= 1'b1;
        @(posedge i_clk);
        halt_go <= 1'b0;
        do begin
            @(posedge i_clk);
            n++;
        end while (halted !== 1'b1 && n < 16);
        if (halted !== 1'b1) give_up();
        check(32'(stop), 32'(e_stop));
        external_interrupt_zero <= (poke == 1);
        nmi <= (poke == 2);
        @(posedge i_clk);
        external_interrupt_zero <= 1'b0;
        nmi <= 1'b0;
    endtask

    task automatic wake_other(input logic [2:0] p);
        other_prio <= p;
        other <= 1'b1;
        @(posedge i_clk);
        other <= 1'b0;
    endtask

    task automatic wait_run(output int cyc);
        cyc = 0;
        do begin
            @(posedge i_clk);
            cyc++;
        end while (sysclk_run !== 1'b1 && cyc < 2000);
        if (sysclk_run !== 1'b1) give_up();
    endtask

    task automatic expect_svc(input shwc_pkg::shwc_req_s a, input shwc_pkg::shwc_req_s b, input int k);
        int n;
        n = 0;
        while (log_q.size() < k && n < 64) begin
            @(posedge i_clk);
            n++;
        end
        if (log_q.size() < k) give_up();
        check(32'(log_q[0]), 32'(a));
        if (k > 1) check(32'(log_q[1]), 32'(b));
        log_q.delete();
    endtask

    function automatic shwc_pkg::shwc_req_s req(input shwc_pkg::shwc_src_e s, input logic [2:0] p);
        return '{valid: 1'b1, src: s, prio: p};
    endfunction

    // the held request wins a tie
    function automatic logic held_first(input logic [2:0] held_p, input logic [2:0] new_p);
        return held_p >= new_p;
    endfunction

    initial begin
        logic [31:0] rd;
        logic [2:0] p0;
        logic [2:0] po;
        logic sel;
        logic [15:0] warm;
        int cyc;
        int ticks;
        void'($urandom(32'h1cb2_188c));
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        check(32'(halted), 32'h0);
        check(32'(sysclk_run), 32'h1);
        check(32'(gate_en), 32'h1);
        bus(1'b0, shwc_pkg::CTRL_OFS, 32'h0, rd);
        check(rd, shwc_pkg::CTRL_RESET);
        bus(1'b0, shwc_pkg::WARM_OFS, 32'h0, rd);
        check(rd, 32'(shwc_pkg::WARM_RESET));
        bus(1'b1, shwc_pkg::HOLD_OFS, 32'h1ff, rd);
        bus(1'b0, shwc_pkg::HOLD_OFS, 32'h0, rd);
        check(rd, 32'h0);
        bus(1'b0, 4'h1, 32'h0, rd);
        check(rd, 32'h0);
        // one state is two selected-clock cycles
        ticks = 0;
        repeat (16) begin
            @(posedge i_clk);
            ticks += (state_tick === 1'b1);
        end
        check(32'(ticks), 32'h8);
        // external_interrupt_zero during entry: wakes in run and peripheral_running_idle_mode, is held in oscillator_only_idle_mode
        for (int m = 0; m < 3; m++) begin
            p0 = 3'($urandom_range(7, 1));
            sel = 1'($urandom);
            bus(1'b1, shwc_pkg::CTRL_OFS, {25'h0, p0, sel, 1'b0, 2'(m)}, rd);
            check(32'(sysclk_sel), 32'(sel));
            halt_and_poke(2'(m), 1, 1'b0);
            if (m < 2) begin
                wait_run(cyc);
                expect_svc(req(shwc_pkg::SRC_EXTERNAL_INTERRUPT_ZERO, p0), req(shwc_pkg::SRC_NONE, 3'h0), 1);
            end else begin
                repeat (12) @(posedge i_clk);
                check(32'(halted), 32'h1);
                bus(1'b0, shwc_pkg::HOLD_OFS, 32'h0, rd);
                check(rd, {23'h0, 1'b1, 1'b0, p0, 2'h0, 2'(shwc_pkg::SRC_EXTERNAL_INTERRUPT_ZERO)});
                po = 3'($urandom);
                wake_other(po);
                wait_run(cyc);
                if (held_first(p0, po)) begin
                    expect_svc(req(shwc_pkg::SRC_EXTERNAL_INTERRUPT_ZERO, p0), req(shwc_pkg::SRC_OTHER, po), 2);
                end else begin
                    expect_svc(req(shwc_pkg::SRC_OTHER, po), req(shwc_pkg::SRC_EXTERNAL_INTERRUPT_ZERO, p0), 2);
                end
            end
        end
        // stop with a held nmi, warm-up on release, slow core
        warm = 16'($urandom_range(24, 2));
        bus(1'b1, shwc_pkg::WARM_OFS, {16'h0, warm}, rd);
        bus(1'b1, shwc_pkg::CTRL_OFS, {25'h0, 3'h2, 1'b0, 1'b0, shwc_pkg::MODE_STOP}, rd);
        halt_and_poke(shwc_pkg::MODE_STOP, 2, 1'b1);
        check(32'(pins_od), 32'h1);
        check(32'(gate_en), 32'h1);
        repeat (8) @(posedge i_clk);
        check(32'(halted), 32'h1);
        ack_slow <= 1'b1;
        po = 3'($urandom);
        wake_other(po);
        @(posedge i_clk);
        check(32'(pins_od), 32'h0);
        check(32'(sysclk_run), 32'h0);
        wait_run(cyc);
        check(32'(cyc >= 2 * warm - 3 && cyc <= 2 * warm + 3), 32'h1);
        expect_svc(req(shwc_pkg::SRC_NMI, shwc_pkg::NMI_PRIO), req(shwc_pkg::SRC_OTHER, po), 2);
        bus(1'b0, shwc_pkg::STAT_OFS, 32'h0, rd);
        check(32'(rd[9:8]), 32'h0);
        ack_slow <= 1'b0;
        // drive bit set: stop signal stays low through a stop halt
        bus(1'b1, shwc_pkg::CTRL_OFS, {25'h0, 3'h2, 1'b0, 1'b1, shwc_pkg::MODE_STOP}, rd);
        halt_and_poke(shwc_pkg::MODE_STOP, 0, 1'b0);
        repeat (4) @(posedge i_clk);
        check(32'(stop), 32'h0);
        po = 3'($urandom);
        wake_other(po);
        wait_run(cyc);
        expect_svc(req(shwc_pkg::SRC_OTHER, po), req(shwc_pkg::SRC_NONE, 3'h0), 1);
        // core keeps the prescaler running into an oscillator_only_idle_mode halt: warning set, then cleared by software
        bus(1'b1, shwc_pkg::CTRL_OFS, {25'h0, 3'h2, 1'b0, 1'b0, shwc_pkg::MODE_OSCILLATOR_ONLY_IDLE_MODE}, rd);
        halt_and_poke(shwc_pkg::MODE_PERIPHERAL_RUNNING_IDLE_MODE, 0, 1'b0);
        repeat (4) @(posedge i_clk);
        wake_other(3'h5);
        wait_run(cyc);
        expect_svc(req(shwc_pkg::SRC_OTHER, 3'h5), req(shwc_pkg::SRC_NONE, 3'h0), 1);
        bus(1'b0, shwc_pkg::STAT_OFS, 32'h0, rd);
        check(32'(rd[9:8]), 32'h1);
        bus(1'b1, shwc_pkg::STAT_OFS, 32'h0000_0100, rd);
        bus(1'b0, shwc_pkg::STAT_OFS, 32'h0, rd);
        check(32'(rd[9:8]), 32'h0);
        report_and_stop();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge i_clk);
        give_up();
    end
endmodule
`default_nettype wire
